// ---- inc/cmh_pkg.sv ----
// constants for the message history list block
// assumes a 32-bit axi4-lite master; byte address is four times the register index
package cmh_pkg;

	// bus geometry
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;

	// register indices; byte address is the index shifted left by two
	localparam logic [15:0] RX_HIST_IDX     = 16'hFF60;
	localparam logic [15:0] TX_HIST_IDX     = 16'hFF62;
	localparam logic [15:0] LAST_SENT_IDX   = 16'hFF68;
	localparam logic [15:0] LAST_STORED_IDX = 16'hFF6A;
	localparam logic [15:0] CTRL_IDX        = 16'hFF6C;
	localparam logic [15:0] INT_STATUS_IDX  = 16'hFF6E;
	localparam logic [15:0] INT_MASK_IDX    = 16'hFF70;

	// history read register layout
	localparam int HIST_ENTRY_LSB = 8;
	localparam int HIST_EMPTY_BIT = 1;
	localparam int HIST_OVF_BIT   = 0;

	// control register layout and reset value
	localparam int         CTRL_OPMODE_BIT = 0;
	localparam int         CTRL_ABT_BIT    = 1;
	localparam int         CTRL_W          = 2;
	localparam logic [1:0] CTRL_RESET      = 2'h0;

	// interrupt status / mask layout
	localparam int         IRQ_RX_STORE = 0;
	localparam int         IRQ_TX_SENT  = 1;
	localparam int         IRQ_RX_OVF   = 2;
	localparam int         IRQ_TX_OVF   = 3;
	localparam int         IRQ_W        = 4;
	localparam logic [3:0] IRQ_RESET    = 4'h0;

	// list depths and buffer range
	localparam int         RX_DEPTH      = 23;
	localparam int         TX_DEPTH      = 7;
	localparam logic [7:0] ABT_LAST_BUF  = 8'h07;
	localparam logic       EMPTY_RESET   = 1'b1;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		CMH_SEL_NONE,
		CMH_SEL_RX_HIST,
		CMH_SEL_TX_HIST,
		CMH_SEL_LAST_SENT,
		CMH_SEL_LAST_STORED,
		CMH_SEL_CTRL,
		CMH_SEL_INT_STATUS,
		CMH_SEL_INT_MASK
	} cmh_reg_sel_t;

endpackage

// ---- hdl/cmh_history_list.sv ----
// one circular history list of message buffer numbers
// assumes store and pop come from logic on aclk, one cycle pulses
`timescale 1ns/100ps
module cmh_history_list import cmh_pkg::*; #(
	parameter int DEPTH = TX_DEPTH
) (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// control
	input  wire logic       hold_clear,
	input  wire logic       store,
	input  wire logic [7:0] store_buf,
	input  wire logic       pop,
	input  wire logic       clear_ovf,
	// state
	output logic [7:0]      get_entry,
	output logic [7:0]      last_entry,
	output logic            empty,
	output logic            ovf,
	output logic            ovf_rise
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [7:0]       mem [DEPTH];
	logic [PTR_W-1:0] put_ptr;
	logic [PTR_W-1:0] get_ptr;
	logic [CNT_W-1:0] count;
	logic             full;
	logic             store_norm;
	logic             store_over;
	logic             pop_ok;

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		return (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
	endfunction

	function automatic logic [PTR_W-1:0] ptr_dec(input logic [PTR_W-1:0] p);
		return (p == '0) ? PTR_W'(DEPTH - 1) : PTR_W'(p - 1'b1);
	endfunction

	assign full       = (count == CNT_W'(DEPTH));
	assign store_norm = store && !ovf && !full;
	assign store_over = store && (ovf || full);
	assign pop_ok     = pop && !empty;
	assign ovf_rise   = store && !ovf && (full || (count == CNT_W'(DEPTH - 1) && !pop_ok));
	assign get_entry  = mem[get_ptr];
	assign last_entry = mem[ptr_dec(put_ptr)];

	always_ff @(posedge aclk) begin
		if (store_norm) begin
			mem[put_ptr] <= store_buf;
		end else if (store_over) begin
			mem[ptr_dec(put_ptr)] <= store_buf;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || hold_clear) begin
			put_ptr <= '0;
			get_ptr <= '0;
			count   <= '0;
		end else begin
			if (store_norm) begin
				put_ptr <= ptr_inc(put_ptr);
			end
			if (pop_ok) begin
				get_ptr <= ptr_inc(get_ptr);
			end
			count <= CNT_W'(count + CNT_W'(store_norm) - CNT_W'(pop_ok));
		end
	end

	// empty flag, store_norm wins over last read
	always_ff @(posedge aclk) begin
		if (!aresetn || hold_clear) begin
			empty <= EMPTY_RESET;
		end else if (store_norm) begin
			empty <= 1'b0;
		end else if (pop_ok && count == CNT_W'(1)) begin
			empty <= 1'b1;
		end
	end

	// overflow flag, set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn || hold_clear) begin
			ovf <= 1'b0;
		end else if (ovf_rise) begin
			ovf <= 1'b1;
		end else if (clear_ovf) begin
			ovf <= 1'b0;
		end
	end

endmodule

// ---- hdl/cmh_history_top.sv ----
// message history lists with axi4-lite register slave
// assumes the can engine reports stores and sends as one-cycle pulses on aclk
`timescale 1ns/100ps

module cmh_history_top import cmh_pkg::*; (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi write address
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// axi write data
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi read address
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// axi read data
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// can engine events
	input  wire logic              rx_stored_valid,
	input  wire logic [7:0]        rx_stored_buf,
	input  wire logic              tx_sent_valid,
	input  wire logic [7:0]        tx_sent_buf,
	// interrupt
	output logic                   irq
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [ADDR_W-1:0] wr_addr;
	logic              aw_held;
	logic [DATA_W-1:0] wr_data;
	logic [3:0]        wr_strb;
	logic              w_held;
	logic              wr_fire;
	cmh_reg_sel_t      wr_sel;
	logic              wr_low;
	logic              wr_ctrl;
	logic              wr_mask;
	logic              wr_status;
	logic              wr_rx_hist;
	logic              wr_tx_hist;
	logic              ar_fire;
	cmh_reg_sel_t      rd_sel;

	logic [CTRL_W-1:0] ctrl;
	logic              op_mode;
	logic              automatic_block_transmission;
	logic [IRQ_W-1:0]  int_status;
	logic [IRQ_W-1:0]  int_mask;
	logic [IRQ_W-1:0]  int_event;

	logic              rx_store;
	logic              rx_pop;
	logic              rx_clr_ovf;
	logic [7:0]        rx_get_pointer_field;
	logic [7:0]        last_stored_entry;
	logic              rx_history_empty;
	logic              rx_history_overflow;
	logic              rx_ovf_rise;

	logic              tx_store;
	logic              tx_abt_skip;
	logic              tx_pop;
	logic              tx_clr_ovf;
	logic [7:0]        tx_get_pointer_field;
	logic [7:0]        last_sent_entry;
	logic              tx_history_empty;
	logic              tx_history_overflow;
	logic              tx_ovf_rise;

	logic [DATA_W-1:0] next_rdata;
	logic [1:0]        next_rresp;

	////////////////////////////////////////////////////////////////////////
	// address decode, shared by read and write

	function automatic cmh_reg_sel_t decode(input logic [ADDR_W-1:0] a);
		cmh_reg_sel_t s;
		s = CMH_SEL_NONE;
		if (a[1:0] == 2'h0) begin
			unique case (a[ADDR_W-1:2])
				RX_HIST_IDX:     s = CMH_SEL_RX_HIST;
				TX_HIST_IDX:     s = CMH_SEL_TX_HIST;
				LAST_SENT_IDX:   s = CMH_SEL_LAST_SENT;
				LAST_STORED_IDX: s = CMH_SEL_LAST_STORED;
				CTRL_IDX:        s = CMH_SEL_CTRL;
				INT_STATUS_IDX:  s = CMH_SEL_INT_STATUS;
				INT_MASK_IDX:    s = CMH_SEL_INT_MASK;
				default:         s = CMH_SEL_NONE;
			endcase
		end
		return s;
	endfunction

	// formats a history read word: entry, empty, overflow
	function automatic logic [DATA_W-1:0] hist_word(input logic [7:0] e, input logic emp, input logic ov);
		logic [DATA_W-1:0] w;
		w = '0;
		w[HIST_ENTRY_LSB +: 8] = e;
		w[HIST_EMPTY_BIT]      = emp;
		w[HIST_OVF_BIT]        = ov;
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order

	// one write in flight at a time; bvalid blocks a second fire
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign wr_sel  = decode(wr_addr);
	assign wr_low  = wr_fire && wr_strb[0];

	// per-register write strobes, byte lane 0 only
	assign wr_ctrl    = wr_low && wr_sel == CMH_SEL_CTRL;
	assign wr_mask    = wr_low && wr_sel == CMH_SEL_INT_MASK;
	assign wr_status  = wr_low && wr_sel == CMH_SEL_INT_STATUS;
	assign wr_rx_hist = wr_low && wr_sel == CMH_SEL_RX_HIST;
	assign wr_tx_hist = wr_low && wr_sel == CMH_SEL_TX_HIST;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			s_axi_awready <= 1'b1;
			wr_addr       <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held       <= 1'b1;
			s_axi_awready <= 1'b0;
			wr_addr       <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_held       <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held       <= 1'b0;
			s_axi_wready <= 1'b1;
			wr_data      <= '0;
			wr_strb      <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held       <= 1'b1;
			s_axi_wready <= 1'b0;
			wr_data      <= s_axi_wdata;
			wr_strb      <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_held       <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_sel == CMH_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control and interrupt registers

	assign op_mode                      = ctrl[CTRL_OPMODE_BIT];
	assign automatic_block_transmission = ctrl[CTRL_ABT_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= wr_data[CTRL_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_mask <= IRQ_RESET;
		end else if (wr_mask) begin
			int_mask <= wr_data[IRQ_W-1:0];
		end
	end

	always_comb begin
		int_event               = '0;
		int_event[IRQ_RX_STORE] = rx_store;
		int_event[IRQ_TX_SENT]  = tx_store;
		int_event[IRQ_RX_OVF]   = rx_ovf_rise;
		int_event[IRQ_TX_OVF]   = tx_ovf_rise;
	end

	// sticky status, event wins over write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_status <= IRQ_RESET;
		end else if (wr_status) begin
			int_status <= (int_status & ~wr_data[IRQ_W-1:0]) | int_event;
		end else begin
			int_status <= int_status | int_event;
		end
	end

	// irq lags status by one cycle so it leaves a flop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status & int_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// history lists; init mode holds both empty

	assign rx_store = op_mode && rx_stored_valid;
	assign tx_abt_skip = automatic_block_transmission && tx_sent_buf <= ABT_LAST_BUF;
	assign tx_store    = op_mode && tx_sent_valid && !tx_abt_skip;
	assign rx_clr_ovf = wr_rx_hist && wr_data[HIST_OVF_BIT];
	assign tx_clr_ovf = wr_tx_hist && wr_data[HIST_OVF_BIT];

	cmh_history_list #(
		.DEPTH      (RX_DEPTH)
	) u_rx_list (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.hold_clear (!op_mode),
		.store      (rx_store),
		.store_buf  (rx_stored_buf),
		.pop        (rx_pop),
		.clear_ovf  (rx_clr_ovf),
		.get_entry  (rx_get_pointer_field),
		.last_entry (last_stored_entry),
		.empty      (rx_history_empty),
		.ovf        (rx_history_overflow),
		.ovf_rise   (rx_ovf_rise)
	);

	cmh_history_list #(
		.DEPTH      (TX_DEPTH)
	) u_tx_list (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.hold_clear (!op_mode),
		.store      (tx_store),
		.store_buf  (tx_sent_buf),
		.pop        (tx_pop),
		.clear_ovf  (tx_clr_ovf),
		.get_entry  (tx_get_pointer_field),
		.last_entry (last_sent_entry),
		.empty      (tx_history_empty),
		.ovf        (tx_history_overflow),
		.ovf_rise   (tx_ovf_rise)
	);

	////////////////////////////////////////////////////////////////////////
	// read channel

	assign ar_fire = s_axi_arvalid && s_axi_arready;
	assign rd_sel  = decode(s_axi_araddr);
	// pop at the take; the answer shows the state before it
	// a history read pops one entry unless that list is empty
	assign rx_pop  = ar_fire && rd_sel == CMH_SEL_RX_HIST;
	assign tx_pop  = ar_fire && rd_sel == CMH_SEL_TX_HIST;

	always_comb begin
		next_rdata = '0;
		next_rresp = RESP_OKAY;
		unique case (rd_sel)
			CMH_SEL_RX_HIST:     next_rdata = hist_word(rx_get_pointer_field, rx_history_empty, rx_history_overflow);
			CMH_SEL_TX_HIST:     next_rdata = hist_word(tx_get_pointer_field, tx_history_empty, tx_history_overflow);
			CMH_SEL_LAST_SENT:   next_rdata[7:0] = last_sent_entry;
			CMH_SEL_LAST_STORED: next_rdata[7:0] = last_stored_entry;
			CMH_SEL_CTRL:        next_rdata[CTRL_W-1:0] = ctrl;
			CMH_SEL_INT_STATUS:  next_rdata[IRQ_W-1:0] = int_status;
			CMH_SEL_INT_MASK:    next_rdata[IRQ_W-1:0] = int_mask;
			CMH_SEL_NONE:        next_rresp = RESP_SLVERR;
		endcase
	end

	// reset shows empty set, overflow clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (ar_fire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

endmodule

// ---- sim/cmh_chk.sv ----
// checker for the history block bus answers and read layout
// assumes binding to cmh_history_top ports
`timescale 1ns/100ps
module cmh_chk import cmh_pkg::*; (
	// clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// write side
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	// read side
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	// interrupt
	input wire logic              irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic hist_rd;

	// remembers whether the pending read targets a history list
	always_ff @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			hist_rd <= (s_axi_araddr == {RX_HIST_IDX, 2'h0}) || (s_axi_araddr == {TX_HIST_IDX, 2'h0});
		end
	end

	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	a_write_answer: assert property (wr_taken |=> ##1 s_axi_bvalid)
		else $error("write not answered");
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read not answered");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while busy");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while busy");
	a_hist_layout: assert property (s_axi_rvalid && hist_rd |-> s_axi_rdata[7:2] == 6'h00 && s_axi_rdata[31:16] == 16'h0000)
		else $error("history read has stray bits");
	a_unmapped_rd: assert property (rd_taken ##0 (s_axi_araddr[1:0] != 2'h0) |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("misaligned read not refused");
	a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs busy after reset");
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the message history lists
// assumes cmh_history_top and cmh_chk are compiled before it
`timescale 1ns/100ps
module tb import cmh_pkg::*;;
	localparam logic [17:0] A_RX = {RX_HIST_IDX, 2'h0};
	localparam logic [17:0] A_TX = {TX_HIST_IDX, 2'h0};
	localparam logic [17:0] A_LS = {LAST_SENT_IDX, 2'h0};
	localparam logic [17:0] A_LI = {LAST_STORED_IDX, 2'h0};
	localparam logic [17:0] A_CT = {CTRL_IDX, 2'h0};
	localparam logic [17:0] A_IS = {INT_STATUS_IDX, 2'h0};
	localparam logic [17:0] A_IM = {INT_MASK_IDX, 2'h0};
	localparam logic [17:0] A_NO = 18'h3FFFC;
	logic              aclk = 1'b0, aresetn = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0]        s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, dat;
	logic [3:0]        s_axi_wstrb = 4'hF;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
	logic              rx_stored_valid = 1'b0, tx_sent_valid = 1'b0;
	logic [7:0]        rx_stored_buf = 8'h00, tx_sent_buf = 8'h00;
	int                bad_count = 0, compares = 0, cyc = 0;

	cmh_history_top u_dut (.*);

	always #50 aclk = ~aclk;
////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("Error %0t: value %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("Error %0t: response %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk_r(s_axi_bresp, er);
	endtask

	task automatic rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	task automatic rc(input logic [17:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a, dat, rsp);
		chk(dat & m, e);
		chk_r(rsp, RESP_OKAY);
	endtask

	// back to back engine events, buffer numbers counting from b0
	task automatic ev(input bit rx, input int n, input int b0);
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			if (rx) begin
				rx_stored_valid <= 1'b1;
				rx_stored_buf <= 8'((b0 + i) % 16);
			end else begin
				tx_sent_valid <= 1'b1;
				tx_sent_buf <= 8'((b0 + i) % 16);
			end
		end
		@(posedge aclk);
		rx_stored_valid <= 1'b0;
		tx_sent_valid <= 1'b0;
	endtask

	task automatic irq_chk(input logic e);
		repeat (2) @(posedge aclk);
		#1 chk({31'h0, irq}, {31'h0, e});
	endtask

	task automatic ovf_test(input bit rx, input int depth, input logic [17:0] ah, input logic [17:0] al);
		ev(rx, depth, 0);
		ev(rx, 1, 9);
		rc(al, 32'hFF, 32'h09);
		for (int i = 0; i < depth - 1; i++) rc(ah, 32'hFFFF, {16'h0, 8'(i % 16), 8'h01});
		rc(ah, 32'hFFFF, 32'h0901);
		rc(ah, 32'hFF, 32'h03);
		ev(rx, 1, 2);
		rc(ah, 32'hFF, 32'h03);
		wr(ah, 32'h0, RESP_OKAY);
		rc(ah, 32'hFF, 32'h03);
		wr(ah, 32'h1, RESP_OKAY);
		rc(ah, 32'hFF, 32'h02);
	endtask
////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			$display("Error %0t: run did not finish", $time);
			final_report;
		end
	end

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rc(A_RX, 32'hFF, 32'h02);
		rc(A_TX, 32'hFF, 32'h02);
		rc(A_IS, 32'hF, 32'h0);
		ev(1, 1, 3);
		rc(A_RX, 32'hFF, 32'h02);
		$display("test reset done");
		wr(A_CT, 32'h1, RESP_OKAY);
		rc(A_CT, 32'h3, 32'h1);
		wr(A_IM, 32'hF, RESP_OKAY);
		rc(A_IM, 32'hF, 32'hF);
		ev(1, 2, 5);
		irq_chk(1'b1);
		rc(A_LI, 32'hFF, 32'h06);
		rc(A_RX, 32'hFFFF, 32'h0500);
		rc(A_RX, 32'hFFFF, 32'h0600);
		rc(A_RX, 32'hFF, 32'h02);
		rc(A_IS, 32'hF, 32'h1);
		wr(A_IS, 32'h1, RESP_OKAY);
		irq_chk(1'b0);
		wr(A_IM, 32'h0, RESP_OKAY);
		ev(1, 1, 1);
		irq_chk(1'b0);
		wr(A_IM, 32'hF, RESP_OKAY);
		irq_chk(1'b1);
		wr(A_IS, 32'hF, RESP_OKAY);
		irq_chk(1'b0);
		rc(A_RX, 32'hFFFF, 32'h0100);
		$display("test rx list done");
		ovf_test(0, TX_DEPTH, A_TX, A_LS);
		rc(A_IS, 32'hF, 32'hA);
		wr(A_IS, 32'hF, RESP_OKAY);
		ovf_test(1, RX_DEPTH, A_RX, A_LI);
		rc(A_IS, 32'hF, 32'h5);
		wr(A_IS, 32'hF, RESP_OKAY);
		$display("test overflow done");
		wr(A_CT, 32'h3, RESP_OKAY);
		rc(A_CT, 32'h3, 32'h3);
		ev(0, 1, 7);
		rc(A_TX, 32'hFF, 32'h02);
		rc(A_IS, 32'hF, 32'h0);
		ev(0, 1, 8);
		rc(A_TX, 32'hFFFF, 32'h0800);
		ev(0, 1, 9);
		wr(A_CT, 32'h0, RESP_OKAY);
		rc(A_TX, 32'hFF, 32'h02);
		$display("test block transmission done");
		rd(A_NO, dat, rsp);
		chk_r(rsp, RESP_SLVERR);
		rd(A_RX + 18'h1, dat, rsp);
		chk(dat, 32'h0);
		wr(A_NO, 32'h1, RESP_SLVERR);
		$display("test unmapped done");
		final_report;
	end
endmodule

bind cmh_history_top cmh_chk u_chk (.*);
